// *** rtl/membank_map.svh ***
// address map, geometry and mode constants for the memory module bank decode
`ifndef MEMBANK_MAP_SVH
`define MEMBANK_MAP_SVH
// ========================================
// address fields
`define ADDR_WIDTH      34
`define SECT_LSB        0
`define SECT_W          3
`define SUBSECT_LSB     3
`define SUBSECT_W       3
`define BANK_LSB        6
`define BANK_W          4
`define WORD_LSB        10
`define WORD_W          24
`define GROUP_LSB       10
// ========================================
// word layout
`define DATA_W          64
`define CHECK_W         12
`define MEM_WORD_W      76
// ========================================
// population geometry
`define SYNC_BANKS      32
`define ASYNC_BANKS     16
`define SYNC_DEPTH_LOG2 20
`define ASYNC_DEPTH_LOG2 21
`define SYNC_CHIP_BITS  4
`define ASYNC_CHIP_BITS 2
`define SECT_BANKS_SYNC 16
`define WORDS_PER_CLK   4
`define ABSENT_BANK_LO  4'h8
`define ABSENT_BANK_HI  4'hf
`endif

// *** rtl/membank_pkg.sv ***
// types shared by the memory module bank decode
package membank_pkg;
	typedef enum logic {POP_SYNC, POP_ASYNC} pop_t;
	typedef enum logic {REF_READ, REF_WRITE} ref_kind_t;
endpackage

// *** rtl/membank_buf.sv ***
// two-entry valid/ready buffer for returned words
`timescale 1ns/1ps
`default_nettype none
module membank_buf #(
	parameter int WIDTH = 76
) (
	input  wire logic             clk_i,   // clock
	input  wire logic             rst_i,   // sync reset, high
	input  wire logic             s_valid_i, // word offered
	output logic                  s_ready_o, // room left
	input  wire logic [WIDTH-1:0] s_data_i,  // word in
	output logic                  m_valid_o, // word held
	input  wire logic             m_ready_i, // sink takes
	output logic      [WIDTH-1:0] m_data_o   // word out
);
	logic [WIDTH-1:0] mem [2];
	logic             wptr;
	logic             rptr;
	logic [1:0]       count;
	wire              push = s_valid_i && s_ready_o;
	wire              pop  = m_valid_o && m_ready_i;

	assign s_ready_o = (count != 2'h2);
	assign m_valid_o = (count != 2'h0);
	assign m_data_o  = mem[rptr];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wptr  <= 1'b0;
			rptr  <= 1'b0;
			count <= 2'h0;
		end
		else
		begin
			if (push)
				wptr <= ~wptr;
			if (pop)
				rptr <= ~rptr;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wptr] <= s_data_i;
	end
endmodule
`default_nettype wire

// *** rtl/membank_ctrl.sv ***
// memory module reference decode, bank storage and read return path
//
// Contract
// - address bits 0-2 section, 3-5 subsection, 6-9 bank.
// - bits 10 upward select word; map reaches sixteen giga-words.
// - writes arrive as two packets, reads as one packet.
// - synchronous: two sections of 16 banks, four words per clock each.
// - synchronous population: 32 banks of one million words.
// - asynchronous population: 16 banks of two million words.
// - chips are 1M x 4 synchronous, 2M x 2 asynchronous.
// - each location holds 76 bits: 64 data, 12 check.
// - check bits stored and returned unchecked; processor corrects errors.
// - degrade forces chosen section, subsection and bank address bits.
// - every bank's storage resides wholly on this module.
// - subsection holds 8/16 banks synchronous, 4/8 asynchronous.
// - asynchronous population lacks banks 10-17 octal.
`timescale 1ns/1ps
`default_nettype none
`include "membank_map.svh"
module membank_ctrl
	import membank_pkg::*;
#(
	parameter int MODEL_WORD_LOG2 = 4,  // log2 of stored words per bank in this model
	parameter int SUBSECT_BANKS   = 16  // banks per subsection in this system
) (
	input  wire logic                     CLOCK_I,        // 25 MHz clock
	input  wire logic                     SYS_RST_I,      // sync reset, high
	input  wire membank_pkg::pop_t        POP_MODE_I,     // static chip population
	input  wire logic [`SECT_W-1:0]       FORCE_SECT_MASK_I,    // degrade mask
	input  wire logic [`SECT_W-1:0]       FORCE_SECT_VAL_I,     // degrade value
	input  wire logic [`SUBSECT_W-1:0]    FORCE_SUBSECT_MASK_I, // degrade mask
	input  wire logic [`SUBSECT_W-1:0]    FORCE_SUBSECT_VAL_I,  // degrade value
	input  wire logic [`BANK_W-1:0]       FORCE_BANK_MASK_I,    // degrade mask
	input  wire logic [`BANK_W-1:0]       FORCE_BANK_VAL_I,     // degrade value
	input  wire logic                     PKT_VALID_I,    // packet present
	output logic                          PKT_READY_O,    // packet taken
	input  wire membank_pkg::ref_kind_t   PKT_KIND_I,     // read or write (first packet)
	input  wire logic [`ADDR_WIDTH-1:0]   PKT_ADDR_I,     // reference address
	input  wire logic [`MEM_WORD_W-1:0]   PKT_DATA_I,     // write word (second packet)
	output logic                          RD_VALID_O,     // read word ready
	input  wire logic                     RD_READY_I,     // receiver takes word
	output logic      [`MEM_WORD_W-1:0]   RD_DATA_O,      // data and check bits
	output logic                          WR_DONE_O,      // write data packet taken, pulse; also pulses for a missing bank
	output logic                          BANK_ABSENT_O,  // last reference hit missing bank
	output logic      [`BANK_W+1:0]       BANK_COUNT_O,   // banks presented, 32 needs six bits
	output logic      [`SECT_W-1:0]       LAST_SECT_O,    // decoded section
	output logic      [`SUBSECT_W-1:0]    LAST_SUBSECT_O, // decoded subsection
	output logic      [1:0]               LAST_GROUP_O    // group bits of last address
);
	import membank_pkg::*;

	localparam int NBANK  = `SYNC_BANKS;
	localparam int NWORDS = 1 << MODEL_WORD_LOG2;

	// parameters that the store and the decode cannot serve
	if (MODEL_WORD_LOG2 < 1 || MODEL_WORD_LOG2 > `ASYNC_DEPTH_LOG2)
		$error("MODEL_WORD_LOG2 out of range");
	if (SUBSECT_BANKS != 4 && SUBSECT_BANKS != 8 && SUBSECT_BANKS != 16)
		$error("SUBSECT_BANKS must be 4, 8 or 16");

	// ========================================
	// address decode with degrade forcing
	function automatic logic [`BANK_W-1:0] force_bits(input logic [`BANK_W-1:0] raw,
		input logic [`BANK_W-1:0] mask, input logic [`BANK_W-1:0] val);
		force_bits = (raw & ~mask) | (val & mask);
	endfunction

	wire [`SECT_W-1:0]    raw_sect    = PKT_ADDR_I[`SECT_LSB +: `SECT_W];
	wire [`SUBSECT_W-1:0] raw_subsect = PKT_ADDR_I[`SUBSECT_LSB +: `SUBSECT_W];
	wire [`BANK_W-1:0]    raw_bank    = PKT_ADDR_I[`BANK_LSB +: `BANK_W];
	wire [`WORD_W-1:0]    raw_word    = PKT_ADDR_I[`WORD_LSB +: `WORD_W];
	wire [`BANK_W-1:0]    sect_forced = force_bits({1'b0, raw_sect}, {1'b0, FORCE_SECT_MASK_I},
		{1'b0, FORCE_SECT_VAL_I});
	wire [`BANK_W-1:0]    sub_forced  = force_bits({1'b0, raw_subsect}, {1'b0, FORCE_SUBSECT_MASK_I},
		{1'b0, FORCE_SUBSECT_VAL_I});
	wire [`SECT_W-1:0]    eff_sect    = sect_forced[`SECT_W-1:0];
	wire [`SUBSECT_W-1:0] eff_subsect = sub_forced[`SUBSECT_W-1:0];
	wire [`BANK_W-1:0]    eff_bank    = force_bits(raw_bank, FORCE_BANK_MASK_I, FORCE_BANK_VAL_I);

	// module holds two sections; the lowest section bit picks the half
	wire                  sect_half   = eff_sect[0];
	wire                  is_async    = (POP_MODE_I == POP_ASYNC);
	// async stacks have no banks 10-17 octal: upper half of bank field absent
	wire                  absent      = is_async && (eff_bank >= `ABSENT_BANK_LO)
		&& (eff_bank <= `ABSENT_BANK_HI);
	// sync: 32 banks as half*16+bank; async: 16 banks as half*8+bank[2:0], bank field msb not used in the index
	wire [4:0]            bank_idx    = is_async ? {1'b0, sect_half, eff_bank[2:0]}
		: {sect_half, eff_bank};
	// limitation: the model keeps the same small depth in both modes, async doubling not stored
	wire [MODEL_WORD_LOG2-1:0] word_idx = raw_word[MODEL_WORD_LOG2-1:0];
	wire [31:0]           store_idx   = 32'(bank_idx) * 32'(NWORDS) + 32'(word_idx);

	assign BANK_COUNT_O = is_async ? 6'(`ASYNC_BANKS) : 6'(`SYNC_BANKS);

	// ========================================
	// bank storage, all banks local to this module
	logic [`MEM_WORD_W-1:0] store [NBANK*NWORDS];

	// ========================================
	// reference sequencer
	typedef enum logic [1:0] {ST_HEAD, ST_DATA} seq_t;
	seq_t                   state;
	seq_t                   next_state;
	logic [31:0]            held_idx;
	logic                   held_absent;
	logic                   buf_ready;
	logic                   rd_push;
	logic [`MEM_WORD_W-1:0] rd_word;
	logic                   wr_commit;
	logic [1:0]             pending;

	// pending counts reads in flight plus buffered words; buffer room alone would let
	// a third read in while an earlier word is still on its way, and the third read's word would be lost
	assign PKT_READY_O = (state == ST_DATA) || (PKT_KIND_I == REF_WRITE) || (buf_ready && pending != 2'h2);
	wire   head_take   = PKT_VALID_I && PKT_READY_O && (state == ST_HEAD);
	wire   rd_take     = head_take && (PKT_KIND_I == REF_READ);
	wire   rd_pop      = RD_VALID_O && RD_READY_I;
	wire   data_take   = PKT_VALID_I && (state == ST_DATA);
	assign wr_commit   = data_take && !held_absent;

	always_comb
	begin
		next_state = state;
		case (state)
			ST_HEAD:
				if (head_take && PKT_KIND_I == REF_WRITE)
					next_state = ST_DATA;
			ST_DATA:
				if (data_take)
					next_state = ST_HEAD;
			default:
				next_state = ST_HEAD;
		endcase
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			state          <= ST_HEAD;
			held_idx       <= 32'h0;
			held_absent    <= 1'b0;
			rd_push        <= 1'b0;
			pending        <= 2'h0;
			rd_word        <= '0;
			WR_DONE_O      <= 1'b0;
			BANK_ABSENT_O  <= 1'b0;
			LAST_SECT_O    <= '0;
			LAST_SUBSECT_O <= '0;
			LAST_GROUP_O   <= 2'h0;
		end
		else
		begin
			state     <= next_state;
			rd_push   <= rd_take;
			pending   <= pending + {1'b0, rd_take} - {1'b0, rd_pop};
			WR_DONE_O <= data_take;
			if (head_take)
			begin
				held_idx       <= store_idx;
				held_absent    <= absent;
				BANK_ABSENT_O  <= absent;
				LAST_SECT_O    <= eff_sect;
				LAST_SUBSECT_O <= eff_subsect;
				LAST_GROUP_O   <= PKT_ADDR_I[`GROUP_LSB +: 2];
				// missing bank returns zeros; check bits pass raw otherwise
				rd_word        <= absent ? '0 : store[store_idx];
			end
		end
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (wr_commit)
			store[held_idx] <= PKT_DATA_I;
	end

	// ========================================
	// return buffer
	membank_buf #(.WIDTH(`MEM_WORD_W)) u_rbuf (
		.clk_i     (CLOCK_I),
		.rst_i     (SYS_RST_I),
		.s_valid_i (rd_push),
		.s_ready_o (buf_ready),
		.s_data_i  (rd_word),
		.m_valid_o (RD_VALID_O),
		.m_ready_i (RD_READY_I),
		.m_data_o  (RD_DATA_O)
	);
endmodule
`default_nettype wire

// *** verif/membank_chk.sv ***
// concurrent checks on the bank decode top ports
`timescale 1ns/1ps
`default_nettype none
module membank_chk
	import membank_pkg::*;
(
	input wire logic                      CLOCK_I,           // clock
	input wire logic                      SYS_RST_I,         // sync reset
	input wire membank_pkg::pop_t         POP_MODE_I,        // population
	input wire logic [2:0]                FORCE_SECT_MASK_I, // degrade mask
	input wire logic [2:0]                FORCE_SECT_VAL_I,  // degrade value
	input wire logic [3:0]                FORCE_BANK_MASK_I, // degrade mask
	input wire logic [3:0]                FORCE_BANK_VAL_I,  // degrade value
	input wire logic                      PKT_VALID_I,       // packet present
	input wire logic                      PKT_READY_O,       // packet taken
	input wire membank_pkg::ref_kind_t    PKT_KIND_I,        // kind
	input wire logic [33:0]               PKT_ADDR_I,        // address
	input wire logic                      RD_VALID_O,        // read word
	input wire logic                      RD_READY_I,        // sink takes
	input wire logic [75:0]               RD_DATA_O,         // read data
	input wire logic                      WR_DONE_O,         // write pulse
	input wire logic                      BANK_ABSENT_O,     // missing bank
	input wire logic [5:0]                BANK_COUNT_O,      // bank count
	input wire logic [2:0]                LAST_SECT_O,       // section
	input wire logic [1:0]                LAST_GROUP_O       // group bits
);
	logic       await_data;
	wire        take  = PKT_VALID_I && PKT_READY_O;
	wire        head  = take && !await_data;
	wire  [3:0] fbank = (PKT_ADDR_I[9:6] & ~FORCE_BANK_MASK_I) | (FORCE_BANK_VAL_I & FORCE_BANK_MASK_I);
	wire  [2:0] fsect = (PKT_ADDR_I[2:0] & ~FORCE_SECT_MASK_I) | (FORCE_SECT_VAL_I & FORCE_SECT_MASK_I);
	always_ff @(posedge CLOCK_I)
		if (SYS_RST_I)
			await_data <= 1'b0;
		else if (take)
			await_data <= head && PKT_KIND_I == REF_WRITE;
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (SYS_RST_I);
	rd_latency_a: assert property (head && PKT_KIND_I == REF_READ |-> ##2 RD_VALID_O)
		else $error("read word late");
	wr_done_a: assert property (take && await_data |=> WR_DONE_O)
		else $error("write done missing");
	wr_pulse_a: assert property (WR_DONE_O |-> $past(take && await_data))
		else $error("write done without data packet");
	write_ready_a: assert property (PKT_VALID_I && (await_data || PKT_KIND_I == REF_WRITE) |-> PKT_READY_O)
		else $error("write packet refused");
	word_hold_a: assert property (RD_VALID_O && !RD_READY_I |=> RD_VALID_O && $stable(RD_DATA_O))
		else $error("read word dropped");
	bank_count_a: assert property (BANK_COUNT_O == (POP_MODE_I == POP_SYNC ? 6'h20 : 6'h10))
		else $error("bank count wrong");
	sect_decode_a: assert property (head |=> LAST_SECT_O == $past(fsect))
		else $error("section decode wrong");
	group_bits_a: assert property (head |=> LAST_GROUP_O == $past(PKT_ADDR_I[11:10]))
		else $error("group bits wrong");
	absent_bank_a: assert property (head && POP_MODE_I == POP_ASYNC |=> BANK_ABSENT_O == $past(fbank[3]))
		else $error("absent bank flag wrong");
endmodule
bind membank_ctrl membank_chk u_chk (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .POP_MODE_I(POP_MODE_I),
	.FORCE_SECT_MASK_I(FORCE_SECT_MASK_I), .FORCE_SECT_VAL_I(FORCE_SECT_VAL_I),
	.FORCE_BANK_MASK_I(FORCE_BANK_MASK_I), .FORCE_BANK_VAL_I(FORCE_BANK_VAL_I), .PKT_VALID_I(PKT_VALID_I),
	.PKT_READY_O(PKT_READY_O), .PKT_KIND_I(PKT_KIND_I), .PKT_ADDR_I(PKT_ADDR_I), .RD_VALID_O(RD_VALID_O),
	.RD_READY_I(RD_READY_I), .RD_DATA_O(RD_DATA_O), .WR_DONE_O(WR_DONE_O), .BANK_ABSENT_O(BANK_ABSENT_O),
	.BANK_COUNT_O(BANK_COUNT_O), .LAST_SECT_O(LAST_SECT_O), .LAST_GROUP_O(LAST_GROUP_O));
`default_nettype wire

// *** verif/rd_sink.sv ***
// read-return sink standing in for the requesting processor
`timescale 1ns/1ps
`default_nettype none
module rd_sink (
	input  wire logic clk_i,   // clock
	input  wire logic stall_i, // hold ready low
	output logic      ready_o  // takes a word
);
	logic [7:0] lfsr    = 8'h01;
	logic       ready_q = 1'b0;
	assign ready_o = ready_q;
	// check bits are taken as they come, correction lives past this point
	always @(posedge clk_i)
	begin
		lfsr    <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		ready_q <= !stall_i && lfsr[1:0] != 2'h0;
	end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the bank decode
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import membank_pkg::*;
	logic clk = 0, rst = 1, vld = 0, stall = 0, pready, rvalid, rready, wdone, absent, ok;
	pop_t pop = POP_SYNC;
	ref_kind_t kind = REF_READ;
	logic [33:0] addr = '0, a, b;
	logic [75:0] wdata = '0, d, rdata;
	logic [2:0] sm = '0, sv = '0, lsect, lsub;
	logic [3:0] bm = '0, bv = '0;
	logic [5:0] cnt;
	logic [1:0] lgrp;
	int num_errors = 0, compares = 0, seed = 32'h301cda24, n;
	logic [75:0] got[$];
	initial forever #20 clk = ~clk;
	membank_ctrl #(.MODEL_WORD_LOG2(4)) dut (.CLOCK_I(clk), .SYS_RST_I(rst), .POP_MODE_I(pop),
		.FORCE_SECT_MASK_I(sm), .FORCE_SECT_VAL_I(sv), .FORCE_SUBSECT_MASK_I(sm), .FORCE_SUBSECT_VAL_I(sv),
		.FORCE_BANK_MASK_I(bm), .FORCE_BANK_VAL_I(bv), .PKT_VALID_I(vld), .PKT_READY_O(pready), .PKT_KIND_I(kind),
		.PKT_ADDR_I(addr), .PKT_DATA_I(wdata), .RD_VALID_O(rvalid), .RD_READY_I(rready), .RD_DATA_O(rdata),
		.WR_DONE_O(wdone), .BANK_ABSENT_O(absent), .BANK_COUNT_O(cnt), .LAST_SECT_O(lsect),
		.LAST_SUBSECT_O(lsub), .LAST_GROUP_O(lgrp));
	rd_sink sink (.clk_i(clk), .stall_i(stall), .ready_o(rready));
	always @(posedge clk)
		if (rvalid && rready)
			got.push_back(rdata);
	function logic [33:0] fold(input logic [33:0] x);
		return {x[33:10], (x[9:6] & ~bm) | (bv & bm), (x[5:3] & ~sm) | (sv & sm), (x[2:0] & ~sm) | (sv & sm)};
	endfunction
	task chk(input logic [75:0] g, input logic [75:0] e);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task pkt(input ref_kind_t k, input logic [33:0] x, input logic [75:0] y);
		vld <= 1;
		kind <= k;
		addr <= x;
		wdata <= y;
		do
		begin
			@(negedge clk) ok = pready;
			@(posedge clk);
		end while (!ok);
	endtask
	// data packet sent with read kind: pairing must ignore it
	task wr(input logic [33:0] x, input logic [75:0] y, input bit done);
		pkt(REF_WRITE, x, '0);
		pkt(REF_READ, x, y);
		vld <= 0;
		@(negedge clk);
		if (done)
			chk(wdone, 1);
		@(posedge clk);
	endtask
	task rd(input logic [33:0] x, input logic [75:0] y);
		pkt(REF_READ, x, '0);
		vld <= 0;
		for (int i = 0; i < 60 && got.size() == 0; i++)
			@(posedge clk);
		chk(got.size() ? got.pop_front() : 'x, y);
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		tally_and_finish;
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 0;
		chk(cnt, 6'h20);
		for (int i = 0; i < 10; i++)
		begin
			a = i ? 34'({$random(seed), $random(seed)}) : '1;
			d = 76'({$random(seed), $random(seed), $random(seed)});
			wr(a, d, 1);
			rd(a, d);
			chk(lgrp, a[11:10]);
		end
		$display("test sync readback done");
		bm <= 4'hf;
		bv <= 4'h5;
		sm <= 3'h4;
		sv <= 3'h4;
		@(posedge clk);
		a[9:6] = 4'h3;
		b = fold(a);
		wr(a, d, 1);
		chk(lsub, a[5:3] | 3'h4);
		bm <= '0;
		sm <= '0;
		@(posedge clk);
		rd(b, d);
		$display("test degrade done");
		stall <= 1;
		n = 0;
		vld <= 1;
		kind <= REF_READ;
		addr <= b;
		for (int i = 0; i < 8; i++)
		begin
			@(negedge clk) ok = pready;
			n += ok;
			@(posedge clk);
		end
		vld <= 0;
		chk(ok, 0);
		stall <= 0;
		repeat (40) @(posedge clk);
		chk(got.size(), n);
		while (got.size())
			chk(got.pop_front(), d);
		$display("test buffer fill done");
		rst <= 1;
		pop <= POP_ASYNC;
		repeat (5) @(posedge clk);
		rst <= 0;
		chk(cnt, 5'h10);
		a[9:6] = 4'h2;
		wr(a, ~d, 1);
		rd(a, ~d);
		a[9:6] = 4'h9;
		wr(a, d, 0);
		rd(a, '0);
		chk(absent, 1);
		$display("test async done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
